// ==== hdl/pcrc_top.v ====
// Function
// RQ1: data width is field 12:8 plus one
// RQ2: polynomial length is field 4:0 plus one
// RQ3: low taps bits 15:1, bit 0 reads zero
// RQ4: high taps bits 15:0 are terms 16-31
// RQ5: data writes fill fifo, reads return zero
// RQ6: shift register writable through both halves
// RQ7: shift register readable, low then high half
// RQ8: shift register resets zero, hardware updates it
// RQ9: count rises on top data bit write
// RQ10: fifo depth 4, 8 or 16 by width
// RQ11: run with data shifts two bits per cycle
// RQ12: disabled module empties fifo, zero count
//
// top of the programmable crc register block: 16-bit register port,
// fifo and shift engine; assumes a single master on the register port
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "pcrc_regs.vh"
module pcrc_top (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  output reg [15:0] rdata_q,
  // status
  output reg busy_q
);
  reg engine_enable_q;
  reg calc_run_q;
  reg lsb_first_q;
  reg [15:0] width_length_config_q;
  reg [15:0] polynomial_terms_low_q;
  reg [15:0] polynomial_terms_high_q;
  reg [15:0] data_low_q;
  reg [15:0] data_high_q;
  reg [15:0] rdata_d;
  reg push;
  reg [31:0] push_word;
  wire [4:0] word_width_minus_one;
  wire [4:0] poly_length_minus_one;
  wire [4:0] depth;
  wire [4:0] fifo_word_count;
  wire [31:0] fifo_out;
  wire word_take;
  wire [31:0] shift_value;
  wire engine_busy;
  wire load_low;
  wire load_high;
  wire [31:0] load_value;
  // see RQ1
  assign word_width_minus_one =
    width_length_config_q[`PCRC_WL_WIDTH_HI:`PCRC_WL_WIDTH_LO];
  // see RQ2
  assign poly_length_minus_one =
    width_length_config_q[`PCRC_WL_LEN_HI:`PCRC_WL_LEN_LO];

  // see RQ10
  function [4:0] depth_for;
    input [4:0] w;
    begin
      if (w > `PCRC_WIDTH_WIDE_MIN) begin
        depth_for = `PCRC_DEPTH_WIDE;
      end else if (w > `PCRC_WIDTH_MID_MIN) begin
        depth_for = `PCRC_DEPTH_MID;
      end else begin
        depth_for = `PCRC_DEPTH_NARROW;
      end
    end
  endfunction
  assign depth = depth_for(word_width_minus_one);

  // see RQ9: the half holding the top data bit completes the word
  always @* begin
    push = 1'b0;
    push_word = {data_high_q, data_low_q};
    if (wr && engine_enable_q) begin
      if (addr == `PCRC_OFF_DATA_LOW &&
          word_width_minus_one < 5'h10) begin
        push = 1'b1;
        push_word = {data_high_q, wdata};
      end else if (addr == `PCRC_OFF_DATA_HIGH &&
                   word_width_minus_one >= 5'h10) begin
        push = 1'b1;
        push_word = {wdata, data_low_q};
      end
    end
  end

  // see RQ6
  assign load_low = wr && addr == `PCRC_OFF_SHIFT_LOW;
  assign load_high = wr && addr == `PCRC_OFF_SHIFT_HIGH;
  assign load_value = load_low ? {shift_value[31:16], wdata} :
    {wdata, shift_value[15:0]};

  always @(posedge clk) begin
    if (rst) begin
      engine_enable_q <= 1'b0;
      calc_run_q <= 1'b0;
      lsb_first_q <= 1'b0;
      width_length_config_q <= `PCRC_RESET_VALUE;
      polynomial_terms_low_q <= `PCRC_RESET_VALUE;
      polynomial_terms_high_q <= `PCRC_RESET_VALUE;
      data_low_q <= `PCRC_RESET_VALUE;
      data_high_q <= `PCRC_RESET_VALUE;
    end else begin
      // run clears itself once fifo and engine are drained
      if (calc_run_q && fifo_word_count == 5'h00 && !engine_busy &&
          !push) begin
        calc_run_q <= 1'b0;
      end
      if (wr) begin
        if (addr == `PCRC_OFF_CONTROL) begin
          engine_enable_q <= wdata[`PCRC_CTL_ENABLE_BIT];
          calc_run_q <= wdata[`PCRC_CTL_RUN_BIT];
          lsb_first_q <= wdata[`PCRC_CTL_LSB_BIT];
        end else if (addr == `PCRC_OFF_WIDTH_LENGTH) begin
          width_length_config_q <= wdata & `PCRC_WL_MASK;
        end else if (addr == `PCRC_OFF_POLY_LOW) begin
          // see RQ3
          polynomial_terms_low_q <= wdata & `PCRC_POLY_LOW_MASK;
        end else if (addr == `PCRC_OFF_POLY_HIGH) begin
          // see RQ4
          polynomial_terms_high_q <= wdata;
        end else if (addr == `PCRC_OFF_DATA_LOW) begin
          data_low_q <= wdata;
        end else if (addr == `PCRC_OFF_DATA_HIGH) begin
          data_high_q <= wdata;
        end
      end
      // disabling clears data_high_q and calc_run_q; data_low_q keeps its value
      if (!engine_enable_q) begin
        data_high_q <= `PCRC_RESET_VALUE;
        calc_run_q <= 1'b0;
      end
    end
  end

  pcrc_fifo u_fifo (
    .clk(clk),
    .rst(rst),
    .flush(!engine_enable_q), // see RQ12
    .depth(depth),
    .push(push), // see RQ5
    .push_data(push_word),
    .pop(word_take),
    .pop_data(fifo_out),
    .count(fifo_word_count)
  );

  pcrc_shift u_shift (
    .clk(clk),
    .rst(rst),
    .taps({polynomial_terms_high_q, polynomial_terms_low_q}),
    .poly_length_minus_one(poly_length_minus_one),
    .word_width_minus_one(word_width_minus_one),
    .lsb_first(lsb_first_q),
    .load(load_low || load_high),
    .load_value(load_value),
    // see RQ11
    .word_valid(calc_run_q && engine_enable_q &&
      fifo_word_count != 5'h00),
    .word_data(fifo_out),
    .word_take(word_take),
    .shift_value(shift_value), // see RQ8
    .busy(engine_busy)
  );

  // read mux; unmapped and write-only offsets read zero
  always @* begin
    rdata_d = 16'h0000;
    if (addr == `PCRC_OFF_CONTROL) begin
      rdata_d[`PCRC_CTL_ENABLE_BIT] = engine_enable_q;
      rdata_d[`PCRC_CTL_COUNT_HI:`PCRC_CTL_COUNT_LO] = fifo_word_count;
      rdata_d[`PCRC_CTL_FULL_BIT] = (fifo_word_count == depth);
      rdata_d[`PCRC_CTL_EMPTY_BIT] = (fifo_word_count == 5'h00);
      rdata_d[`PCRC_CTL_RUN_BIT] = calc_run_q;
      rdata_d[`PCRC_CTL_LSB_BIT] = lsb_first_q;
    end else if (addr == `PCRC_OFF_WIDTH_LENGTH) begin
      rdata_d = width_length_config_q;
    end else if (addr == `PCRC_OFF_POLY_LOW) begin
      rdata_d = polynomial_terms_low_q;
    end else if (addr == `PCRC_OFF_POLY_HIGH) begin
      rdata_d = polynomial_terms_high_q;
    end else if (addr == `PCRC_OFF_SHIFT_LOW) begin
      rdata_d = shift_value[15:0]; // see RQ7
    end else if (addr == `PCRC_OFF_SHIFT_HIGH) begin
      rdata_d = shift_value[31:16]; // see RQ7
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
      busy_q <= 1'b0;
    end else begin
      // data registers fall to the zero default here, see RQ5
      rdata_q <= rd ? rdata_d : 16'h0000;
      busy_q <= engine_busy || calc_run_q;
    end
  end
endmodule

// ==== hdl/pcrc_regs.vh ====
// register offsets, field positions, reset values and depth limits
// for the programmable crc register block; included by every design file
`ifndef PCRC_REGS_VH
`define PCRC_REGS_VH
`define PCRC_ADDR_W 4
`define PCRC_OFF_CONTROL 4'h0
`define PCRC_OFF_WIDTH_LENGTH 4'h1
`define PCRC_OFF_POLY_LOW 4'h2
`define PCRC_OFF_POLY_HIGH 4'h3
`define PCRC_OFF_DATA_LOW 4'h4
`define PCRC_OFF_DATA_HIGH 4'h5
`define PCRC_OFF_SHIFT_LOW 4'h6
`define PCRC_OFF_SHIFT_HIGH 4'h7
`define PCRC_CTL_ENABLE_BIT 15
`define PCRC_CTL_RUN_BIT 4
`define PCRC_CTL_LSB_BIT 3
`define PCRC_CTL_FULL_BIT 7
`define PCRC_CTL_EMPTY_BIT 6
`define PCRC_CTL_COUNT_HI 12
`define PCRC_CTL_COUNT_LO 8
`define PCRC_WL_WIDTH_HI 12
`define PCRC_WL_WIDTH_LO 8
`define PCRC_WL_LEN_HI 4
`define PCRC_WL_LEN_LO 0
`define PCRC_WL_MASK 16'h1F1F
`define PCRC_POLY_LOW_MASK 16'hFFFE
`define PCRC_RESET_VALUE 16'h0000
`define PCRC_DEPTH_WIDE 5'h04
`define PCRC_DEPTH_MID 5'h08
`define PCRC_DEPTH_NARROW 5'h10
`define PCRC_WIDTH_MID_MIN 5'h07
`define PCRC_WIDTH_WIDE_MIN 5'h0F
`endif

// ==== hdl/pcrc_fifo.v ====
// word fifo of up to sixteen 32-bit entries with a depth limit
// set by the data width; assumes one clock and synchronous reset
`timescale 1ns/10ps
`include "pcrc_regs.vh"
module pcrc_fifo (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire flush,
  input wire [4:0] depth,
  // fill side
  input wire push,
  input wire [31:0] push_data,
  // drain side
  input wire pop,
  output wire [31:0] pop_data,
  output wire [4:0] count
);
  reg [31:0] mem [0:15];
  reg [3:0] wr_q;
  reg [3:0] rd_q;
  reg [4:0] cnt_q;
  wire do_push;
  wire do_pop;
  // a push beyond the width-dependent depth is dropped
  assign do_push = push && (cnt_q < depth);
  assign do_pop = pop && (cnt_q != 5'h00);
  assign pop_data = mem[rd_q];
  assign count = cnt_q;
  always @(posedge clk) begin
    if (do_push && !flush) begin
      mem[wr_q] <= push_data;
    end
  end
  always @(posedge clk) begin
    if (rst || flush) begin
      wr_q <= 4'h0;
      rd_q <= 4'h0;
      cnt_q <= 5'h00;
    end else begin
      if (do_push) begin
        wr_q <= wr_q + 4'h1;
      end
      if (do_pop) begin
        rd_q <= rd_q + 4'h1;
      end
      if (do_push && !do_pop) begin
        cnt_q <= cnt_q + 5'h01;
      end else if (do_pop && !do_push) begin
        cnt_q <= cnt_q - 5'h01;
      end
    end
  end
endmodule

// ==== hdl/pcrc_shift.v ====
// crc shift engine: two data bits per cycle into a 32-bit lfsr with
// programmable taps and length; assumes one clock and synchronous reset
`timescale 1ns/10ps
`include "pcrc_regs.vh"
module pcrc_shift (
  // clock and reset
  input wire clk,
  input wire rst,
  // configuration
  input wire [31:0] taps,
  input wire [4:0] poly_length_minus_one,
  input wire [4:0] word_width_minus_one,
  input wire lsb_first,
  // software preload
  input wire load,
  input wire [31:0] load_value,
  // word source
  input wire word_valid,
  input wire [31:0] word_data,
  output wire word_take,
  // state
  output wire [31:0] shift_value,
  output wire busy
);
  reg [31:0] crc_q;
  reg [31:0] buf_q;
  reg [5:0] left_q;
  reg [31:0] crc_d;
  reg [31:0] pick;
  integer i;
  // one lfsr step; bit 0 term is always fed back
  function [31:0] step;
    input [31:0] c;
    input [31:0] t;
    input [4:0] len;
    input din;
    reg fb;
    begin
      fb = c[len] ^ din;
      step = ((c << 1) ^ ({32{fb}} & (t | 32'h0000_0001)));
    end
  endfunction
  assign busy = (left_q != 6'h00);
  assign word_take = word_valid && !busy && !load;
  assign shift_value = crc_q;
  always @* begin
    crc_d = crc_q;
    pick = buf_q;
    for (i = 0; i < 2; i = i + 1) begin
      if (left_q > i[5:0]) begin
        crc_d = step(crc_d, taps, poly_length_minus_one,
          lsb_first ? pick[0] : pick[word_width_minus_one]);
        pick = lsb_first ? (pick >> 1) : (pick << 1);
      end
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      crc_q <= 32'h0000_0000;
      buf_q <= 32'h0000_0000;
      left_q <= 6'h00;
    end else if (load) begin
      crc_q <= load_value;
    end else if (busy) begin
      crc_q <= crc_d;
      buf_q <= pick;
      left_q <= (left_q > 6'h02) ? left_q - 6'h02 : 6'h00;
    end else if (word_take) begin
      buf_q <= word_data;
      left_q <= {1'b0, word_width_minus_one} + 6'h01;
    end
  end
endmodule

// ==== verif/pcrc_props.sv ====
// assertions on the register port of the crc block
// assumes one clock and a synchronous active-high reset
`timescale 1ns/10ps
module pcrc_props (
  // clock and reset
  input wire clk,
  input wire rst,
  // register port
  input wire [3:0] addr,
  input wire [15:0] wdata,
  input wire wr,
  input wire rd,
  input wire [15:0] rdata_q,
  // status
  input wire busy_q
);
  reg [15:0] wl_q;
  reg [15:0] ph_q;
  // depth bound: the same width limits and depths as depth_for in the design
  wire [4:0] lim = wl_q[12:8] > 5'h0f ? 5'h04 :
    wl_q[12:8] > 5'h07 ? 5'h08 : 5'h10;
  always @(posedge clk) begin
    if (rst) begin
      wl_q <= 16'h0000;
      ph_q <= 16'h0000;
    end else if (wr && addr == 4'h1) begin
      wl_q <= wdata;
    end else if (wr && addr == 4'h3) begin
      ph_q <= wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(logic [3:0] a);
    rd && addr == a;
  endsequence
  sequence s_load;
    wr && addr == 4'h6 && !busy_q ##2 rd && addr == 4'h6 && !busy_q;
  endsequence
  sequence s_off;
    wr && addr == 4'h0 && !wdata[15] ##2 rd && addr == 4'h0;
  endsequence
  a_idle_read_zero: assert property (
    !rd ##1 1 |-> rdata_q == 16'h0000) else $error("idle read data");
  a_data_read_zero: assert property (
    rd && (addr == 4'h4 || addr == 4'h5) |=> rdata_q == 16'h0000)
    else $error("data register read not zero");
  a_poly_low_b0: assert property (
    s_rd(4'h2) |=> !rdata_q[0]) else $error("poly low bit 0 set");
  a_wl_readback: assert property (
    s_rd(4'h1) |=> rdata_q == (wl_q & 16'h1f1f))
    else $error("width length readback");
  a_poly_high_rb: assert property (
    s_rd(4'h3) |=> rdata_q == ph_q) else $error("poly high readback");
  a_unmapped_zero: assert property (
    rd && addr[3] |=> rdata_q == 16'h0000) else $error("unmapped read");
  a_shift_rb: assert property (
    s_load |=> rdata_q == $past(wdata, 3)) else $error("shift readback");
  a_disable_empty: assert property (
    s_off |=> rdata_q[12:8] == 5'h00 && rdata_q[6])
    else $error("fifo not empty after disable");
  a_count_limit: assert property (
    s_rd(4'h0) |=> rdata_q[12:8] <= lim) else $error("count over depth");
endmodule

bind pcrc_top pcrc_props i_pcrc_props (.clk(clk), .rst(rst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .busy_q(busy_q));

// ==== verif/testbench.sv ====
// self-checking bench for the crc register block over its register port
// assumes the design and checker are compiled first, hdl/ on include path
`timescale 1ns/10ps
module testbench;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [3:0] addr = 4'h0;
  reg [15:0] wdata = 16'h0000;
  reg wr = 1'b0;
  reg rd = 1'b0;
  wire [15:0] rdata_q;
  wire busy_q;
  integer mismatches = 0;
  integer checks = 0;
  integer i;
  integer j;
  integer n;

  pcrc_top i_pcrc_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata_q(rdata_q), .busy_q(busy_q));

  always #2 clk = ~clk;

  function [15:0] ctl(input [4:0] c, input [4:0] d);
    ctl = 16'h8000 | {3'h0, c, 8'h00} | (c == d ? 16'h0080 : 16'h0000)
      | (c == 5'h00 ? 16'h0040 : 16'h0000);
  endfunction

  // reference for a 16-bit polynomial over a 32-bit word, either bit order
  function [15:0] crc16(input [15:0] c, input [31:0] d, input lsb);
    integer k;
    begin
      crc16 = c;
      for (k = 31; k >= 0; k = k - 1)
        crc16 = {crc16[14:0], 1'b0} ^
          ((crc16[15] ^ d[lsb ? 31 - k : k]) ? 16'h1021 : 16'h0000);
    end
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task wr_reg(input [3:0] a, input [15:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask

  task rchk(input [3:0] a, input [15:0] e);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata_q, e);
    end
  endtask

  // counts busy cycles of one run; bounded so a hung engine fails the check
  task drain;
    begin
      n = 0;
      for (i = 0; i < 64 && (n == 0 || busy_q === 1'b1); i = i + 1) begin
        @(posedge clk);
        #1;
        if (busy_q === 1'b1)
          n = n + 1;
      end
    end
  endtask

  task results;
    begin
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  initial begin
    #20000;
    mismatches = mismatches + 1;
    results;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
      rchk(i[3:0], i == 0 ? 16'h0040 : 16'h0000);
    wr_reg(4'h1, 16'hffff);
    rchk(4'h1, 16'h1f1f);
    wr_reg(4'h2, 16'hffff);
    rchk(4'h2, 16'hfffe);
    wr_reg(4'h3, 16'ha5c3);
    rchk(4'h3, 16'ha5c3);
    wr_reg(4'h9, 16'hffff);
    rchk(4'h9, 16'h0000);
    wr_reg(4'h6, 16'h1357);
    rchk(4'h6, 16'h1357);
    wr_reg(4'h7, 16'hbeef);
    rchk(4'h7, 16'hbeef);
    rchk(4'h6, 16'h1357);
    // widest words: count moves only on the high half
    wr_reg(4'h0, 16'h8000);
    for (i = 0; i < 5; i = i + 1) begin
      wr_reg(4'h4, 16'h0001);
      rchk(4'h0, ctl(i[4:0], 5'h04));
      wr_reg(4'h5, 16'h0002);
      rchk(4'h5, 16'h0000);
      rchk(4'h0, ctl(5'(i > 3 ? 4 : i + 1), 5'h04));
    end
    for (j = 8; j > 0; j = j - 5) begin
      wr_reg(4'h0, 16'h0000);
      rchk(4'h0, 16'h0040);
      wr_reg(4'h1, {3'h0, j[4:0], 8'h1f});
      wr_reg(4'h0, 16'h8000);
      for (i = 0; i < 17; i = i + 1)
        wr_reg(4'h4, 16'h00a5);
      rchk(4'h0, ctl(j == 8 ? 5'h08 : 5'h10, j == 8 ? 5'h08 : 5'h10));
    end
    wr_reg(4'h0, 16'h0000);
    wr_reg(4'h1, 16'h1f0f);
    wr_reg(4'h2, 16'h1021);
    wr_reg(4'h3, 16'h0000);
    wr_reg(4'h6, 16'h0000);
    wr_reg(4'h7, 16'h0000);
    wr_reg(4'h0, 16'h8000);
    wr_reg(4'h4, 16'h5678);
    wr_reg(4'h5, 16'h1234);
    wr_reg(4'h0, 16'h8010);
    drain;
    chk({15'h0000, n >= 16 && n <= 20}, 16'h0001);
    rchk(4'h6, crc16(16'h0000, 32'h1234_5678, 1'b0));
    rchk(4'h0, 16'h8040);
    // same word again, shifted in lsb first from a cleared result
    wr_reg(4'h6, 16'h0000);
    wr_reg(4'h7, 16'h0000);
    wr_reg(4'h0, 16'h8008);
    wr_reg(4'h4, 16'h5678);
    wr_reg(4'h5, 16'h1234);
    wr_reg(4'h0, 16'h8018);
    drain;
    chk({15'h0000, n >= 16 && n <= 20}, 16'h0001);
    rchk(4'h6, crc16(16'h0000, 32'h1234_5678, 1'b1));
    rchk(4'h0, 16'h8048);
    results;
  end
endmodule
